// [test/lcd_link_asserts.sv]
// Concurrent checks on the pixel link and the segment driver outputs
`timescale 1ns/1ps
module lcd_link_asserts (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         data_shift_strobe,
  input  wire logic         line_latch_pulse,
  input  wire logic         ac_polarity,
  input  wire logic         forced_blank_n,
  input  wire logic         shift_direction_select,
  input  wire logic         chain_enable_io1_out,
  input  wire logic         chain_enable_io1_oe,
  input  wire logic         chain_enable_io2_out,
  input  wire logic         chain_enable_io2_oe,
  input  wire logic [159:0] seg_level,
  input  wire logic         self_refresh
);
  logic        latch_q;
  logic        strobe_q;
  logic        fall_l;
  logic        fall_s;
  logic        chain_o;
  logic [4:0]  cnt;
  logic [3:0]  since;
  logic [79:0] hi;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  //////////////////////////////////////////////////////////////////////////
  // Raw pin edges; the driver sees them later through its synchronisers
  assign fall_l = latch_q && !line_latch_pulse;
  assign fall_s = strobe_q && !data_shift_strobe;
  assign chain_o = shift_direction_select ? chain_enable_io2_out
                                          : chain_enable_io1_out;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      latch_q <= line_latch_pulse;
      strobe_q <= data_shift_strobe;
    end
  end

  // Strobe falls since the last latch fall, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 5'h00;
    else if (fall_l) cnt <= 5'h00;
    else if (fall_s && cnt != 5'h1F) cnt <= cnt + 5'h01;
  end

  // Cycles since any event allowed to move the outputs; reset counts,
  // since the driver's synchronisers settle a few cycles after it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since <= 4'h0;
    else if (fall_l || $changed(forced_blank_n) || $changed(ac_polarity))
      since <= 4'h0;
    else if (since != 4'hF) since <= since + 4'h1;
  end

  // Upper bit of each column code tells the polarity half
  always_comb begin
    for (int i = 0; i < 80; i++) hi[i] = seg_level[2*i+1];
  end

  //////////////////////////////////////////////////////////////////////////
  refresh_enter_a:
  assert property (fall_l && cnt == 5'h00 |-> ##[3:6] self_refresh)
    else $error("self refresh not entered after idle line");
  refresh_exit_a:
  assert property (fall_l && cnt != 5'h00 |-> ##[3:6] !self_refresh)
    else $error("self refresh kept after data line");
  refresh_steady_a:
  assert property ($changed(self_refresh) |-> since <= 4'h6)
    else $error("self refresh moved away from a line latch");
  seg_steady_a:
  assert property ($changed(seg_level) |-> since <= 4'h6)
    else $error("segment levels moved without a cause");
  chain_set_a:
  assert property (line_latch_pulse [*5] |-> chain_o)
    else $error("chain enable not set by line latch");
  chain_hold_a:
  assert property (cnt < 5'h14 |-> chain_o)
    else $error("chain enable passed before a full line");
  chain_clear_a:
  assert property (fall_s && cnt == 5'h13 |-> ##[2:6] !chain_o)
    else $error("chain enable not passed after twenty nibbles");
  pin_dir_low_a:
  assert property (!shift_direction_select [*4] |->
                   chain_enable_io1_oe && !chain_enable_io2_oe)
    else $error("chain pin direction wrong for select low");
  pin_dir_high_a:
  assert property (shift_direction_select [*4] |->
                   chain_enable_io2_oe && !chain_enable_io1_oe)
    else $error("chain pin direction wrong for select high");
  blank_out_a:
  assert property (fall_l && !forced_blank_n |-> ##4 seg_level == '0)
    else $error("blanked segments not at level zero");
  polarity_code_a:
  assert property (fall_l && forced_blank_n |->
                   ##4 hi == {80{!ac_polarity}})
    else $error("segment levels not in the polarity half");
endmodule

// [test/tb.sv]
// Self-checking bench: display controller and segment driver on one link
`timescale 1ns/1ps
`include "lcd_defs.svh"
module tb;
  typedef struct packed {
    logic [3:0] nib;
    logic       sr;
    logic       bl;
    logic       shl;
    logic       park;
  } exp_t;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, rd_dp;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic         shift_direction_select, self_refresh, io1_w, io2_w;
  logic         chain_enable_io1_out, chain_enable_io1_oe;
  logic         chain_enable_io2_out, chain_enable_io2_oe;
  logic [159:0] seg_level;
  logic [3:0]   nib [2];
  int           mismatches, checked, line_no, frames;
  logic [31:0]  rq [$];
  exp_t         eq [$];
  exp_t         e;
  logic [159:0] xs;
  logic         strobe_pin;
  // Phases: stream, refresh, blank, park, resume, reversed, reversed park
  logic [3:0]   pc [7] = '{4'h7, 4'h5, 4'h9, 4'hD, 4'h7, 4'h7, 4'hD};
  logic         ps [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic         pd [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  int           pn [7] = '{8, 4, 4, 4, 4, 4, 4};

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////
  lcd_link_if lcd_link_if_inst ();
  lcd_display_controller lcd_display_controller_inst (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp(), .hrdata, .link(lcd_link_if_inst));
  lcd_segment_driver lcd_segment_driver_inst (.hclk, .hresetn,
    .link(lcd_link_if_inst), .shift_direction_select,
    .chain_enable_io1_in(io1_w), .chain_enable_io1_out, .chain_enable_io1_oe,
    .chain_enable_io2_in(io2_w), .chain_enable_io2_out, .chain_enable_io2_oe,
    .seg_level, .self_refresh);
  lcd_link_asserts lcd_link_asserts_inst (.hclk, .hresetn,
    .data_shift_strobe(lcd_link_if_inst.data_shift_strobe),
    .line_latch_pulse(lcd_link_if_inst.line_latch_pulse),
    .ac_polarity(lcd_link_if_inst.ac_polarity),
    .forced_blank_n(lcd_link_if_inst.forced_blank_n),
    .shift_direction_select, .chain_enable_io1_out, .chain_enable_io1_oe,
    .chain_enable_io2_out, .chain_enable_io2_oe, .seg_level, .self_refresh);
  // A released enable pin sits at the first driver's tie-low
  assign io1_w = chain_enable_io1_oe ? chain_enable_io1_out : 1'b0;
  assign io2_w = chain_enable_io2_oe ? chain_enable_io2_out : 1'b0;
  assign strobe_pin = lcd_link_if_inst.data_shift_strobe;

  //////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task check(input string n, input logic [159:0] x, input logic [159:0] g);
    checked++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      mismatches++;
    end
  endtask

  // One single AHB-Lite transfer, zero or more wait states
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    ahb(1'b0, a, 32'h0, 3'h2);
  endtask

  // Uniform nibble pattern keeps nibble order out of the expectation
  task setpat(input logic [3:0] n);
    ahb(1'b1, `REG_DATA0, {8{n}}, 3'h2);
    ahb(1'b1, `REG_DATA1, {8{n}}, 3'h2);
    ahb(1'b1, `REG_DATA2, {16'h0, {4{n}}}, 3'h2);
  endtask

  function automatic logic [159:0] exp_seg(input logic [3:0] n,
                                           input logic p, input exp_t x);
    logic px;
    for (int i = 0; i < 80; i++) begin
      px = x.shl ? n[3 - i % 4] : n[i % 4];
      exp_seg[2*i +: 2] = !x.bl ? lcd_pkg::DRIVE_LEVEL_0 :
        p ? (px ? lcd_pkg::DRIVE_LEVEL_0 : lcd_pkg::DRIVE_LEVEL_2) :
            (px ? lcd_pkg::DRIVE_LEVEL_5 : lcd_pkg::DRIVE_LEVEL_3);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Read data taken at the edge that ends each read data phase
  always @(posedge hclk) begin
    if (rd_dp === 1'b1 && rq.size() > 0)
      check("hrdata", 160'(rq.pop_front()), 160'(hrdata));
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  // Line tracking from the frame pin; settled outputs checked per line
  initial begin
    forever begin
      @(negedge lcd_link_if_inst.line_latch_pulse);
      line_no = lcd_link_if_inst.frame_start_pulse ? 0 : line_no + 1;
      if (lcd_link_if_inst.frame_start_pulse) frames++;
      if (eq.size() > 0) begin
        e = eq.pop_front();
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        xs = exp_seg(e.nib ^ line_no[3:0], ~frames[0], e);
        check("seg_level", xs, seg_level);
        check("self_refresh", 160'(e.sr), 160'(self_refresh));
        if (e.sr)
          check("strobe", 160'(e.park), 160'(strobe_pin));
      end
    end
  end

  // Hang guard, well beyond the thirty-odd lines of the run
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    end_sim;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    shift_direction_select = 1'b0;
    rd_dp = 1'b0;
    mismatches = 0;
    checked = 0;
    line_no = 0;
    frames = 0;
    void'($urandom(32'hFC9A74BF));
    nib[0] = 4'($urandom);
    nib[1] = nib[0] ^ 4'(1 + $urandom % 15);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`REG_CTRL, 32'(`CTRL_RESET));
    rd(`REG_LINES, 32'(`LINES_RESET));
    rd(`REG_STROBES, 32'(`STROBES_RESET));
    rd(8'h40, 32'h0);
    rd(`REG_STATUS, 32'h0);
    ahb(1'b1, `REG_LINES, 32'h5, 3'h1);
    rd(`REG_LINES, 32'(`LINES_RESET));
    ahb(1'b1, `REG_LINES, 32'h4, 3'h2);
    setpat(nib[0]);
    rd(`REG_DATA0, {8{nib[0]}});
    rd(`REG_DATA2, {16'h0, {4{nib[0]}}});
    ahb(1'b1, `REG_CTRL, 32'h7, 3'h2);
    @(negedge lcd_link_if_inst.line_latch_pulse);
    // Each change but the strobe count write lands in the gap, before the next line starts
    for (int k = 0; k < 7; k++) begin
      ahb(1'b1, `REG_CTRL, {28'h0, pc[k]}, 3'h2);
      shift_direction_select <= ps[k];
      if (k == 1) begin
        setpat(nib[1]);
        ahb(1'b1, `REG_STROBES, 32'h18, 3'h2);
      end
      repeat (pn[k])
        eq.push_back(exp_t'{nib[pd[k]], !pc[k][1], pc[k][2], ps[k],
                            pc[k][3]});
      repeat (pn[k]) @(negedge lcd_link_if_inst.line_latch_pulse);
    end
    // Let the last line's check run before the verdict
    repeat (8) @(posedge hclk);
    check("pending", 160'h0, 160'(eq.size()));
    end_sim;
  end
endmodule

// [verilog/lcd_defs.svh]
// Shared constants for the segment driver and its display controller
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH
// Display geometry
`define LINE_BITS       80
`define LINE_NIBBLES    5'h14
`define ROW_COUNT       8'hC8
`define ROW_LAST        8'hC7
// Controller link timing: one strobe slot is 8 hclk cycles (320 ns)
`define LINK_PERIOD_NS  320
`define HCLK_PERIOD_NS  40
`define PHASE_LAST      3'(`LINK_PERIOD_NS / `HCLK_PERIOD_NS - 1)
`define PHASE_FALL      3'h4
// Controller register offsets
`define REG_CTRL        8'h00
`define REG_LINES       8'h04
`define REG_DATA0       8'h08
`define REG_DATA1       8'h0C
`define REG_DATA2       8'h10
`define REG_STROBES     8'h14
`define REG_STATUS      8'h18
// Control fields
`define CTRL_RUN        0
`define CTRL_STREAM     1
`define CTRL_BLANK_N    2
`define CTRL_PARK       3
// Reset values
`define CTRL_RESET      4'h6
`define LINES_RESET     8'hC8
`define STROBES_RESET   8'h14
`endif

// [verilog/lcd_display_controller.sv]
// Display controller: AHB-Lite registers and pixel link generator
`timescale 1ns/1ps
`include "lcd_defs.svh"
module lcd_display_controller (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  lcd_link_if.controller   link
);

  logic [3:0]           ctrl;
  logic [7:0]           lines;
  logic [7:0]           strobes;
  logic [79:0]          pattern;
  logic                 wr_q;
  logic [7:0]           addr_q;
  lcd_pkg::ctrl_state_t state;
  logic [2:0]           ph;
  logic [7:0]           slot;
  logic [4:0]           nib_idx;
  logic [7:0]           line;
  logic                 streaming;
  logic                 strobe;
  logic [3:0]           nib;
  logic                 lp;
  logic                 fs;
  logic                 pol;
  logic [6:0]           nib_lo;
  logic                 addr_ok;

  //////////////////////////////////////////////////////////////////////////
  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & htrans[1] & hready & (hsize == 3'h2);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q   <= addr_ok & hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Register writes in the data phase; unmapped offsets ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= `CTRL_RESET;
      lines   <= `LINES_RESET;
      strobes <= `STROBES_RESET;
      pattern <= 80'h0;
    end else if (wr_q) begin
      case (addr_q)
        `REG_CTRL:    ctrl            <= hwdata[3:0];
        `REG_LINES:   lines           <= hwdata[7:0];
        `REG_STROBES: strobes         <= hwdata[7:0];
        `REG_DATA0:   pattern[31:0]   <= hwdata;
        `REG_DATA1:   pattern[63:32]  <= hwdata;
        `REG_DATA2:   pattern[79:64]  <= hwdata[15:0];
        default:      ;
      endcase
    end
  end

  // Read data registered at the address phase so it stands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_ok & ~hwrite) begin
      case (haddr[7:0])
        `REG_CTRL:    hrdata <= {28'h0, ctrl};
        `REG_LINES:   hrdata <= {24'h0, lines};
        `REG_STROBES: hrdata <= {24'h0, strobes};
        `REG_DATA0:   hrdata <= pattern[31:0];
        `REG_DATA1:   hrdata <= pattern[63:32];
        `REG_DATA2:   hrdata <= {16'h0, pattern[79:64]};
        `REG_STATUS:  hrdata <= {16'h0, line, 5'h0, pol, streaming,
                                 (state != lcd_pkg::ST_IDLE)};
        default:      hrdata <= 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // First nibble of a line comes from the top of the pattern
  assign nib_lo = 7'h4C - {nib_idx, 2'b00};

  // Line sequencer; stream choice only changes at line start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= lcd_pkg::ST_IDLE;
      ph        <= 3'h0;
      slot      <= 8'h00;
      nib_idx   <= 5'h00;
      line      <= 8'h00;
      streaming <= 1'b0;
      strobe    <= 1'b0;
      nib       <= 4'h0;
      lp        <= 1'b0;
      fs        <= 1'b0;
      pol       <= 1'b0;
    end else begin
      ph <= (state == lcd_pkg::ST_IDLE) ? 3'h0 : ph + 3'h1;
      unique case (state)
        lcd_pkg::ST_IDLE: begin
          strobe <= ctrl[`CTRL_PARK];
          nib    <= 4'h0;
          if (ctrl[`CTRL_RUN]) begin
            state     <= lcd_pkg::ST_SHIFT;
            streaming <= ctrl[`CTRL_STREAM];
            slot      <= 8'h00;
            nib_idx   <= 5'h00;
          end
        end
        lcd_pkg::ST_SHIFT: begin
          if (!streaming) begin
            strobe <= ctrl[`CTRL_PARK];
            nib    <= 4'h0;
          end else if (ph == 3'h0) begin
            strobe <= 1'b1;
            nib    <= pattern[nib_lo +: 4] ^ line[3:0];
          end else if (ph == `PHASE_FALL) begin
            strobe <= 1'b0;
          end
          if (ph == `PHASE_LAST) begin
            slot    <= slot + 8'h01;
            nib_idx <= (nib_idx == `LINE_NIBBLES - 5'h01) ? 5'h00
                       : nib_idx + 5'h01;
            // Enough strobes for every cascaded driver
            if (slot == strobes - 8'h01) begin
              state <= lcd_pkg::ST_LATCH;
            end
          end
        end
        lcd_pkg::ST_LATCH: begin
          if (ph == 3'h0) begin
            lp <= 1'b1;
            fs <= (line == 8'h00);
          end else if (ph == `PHASE_LAST) begin
            lp    <= 1'b0;
            state <= lcd_pkg::ST_GAP;
          end
        end
        lcd_pkg::ST_GAP: begin
          // Frame start outlives the latch fall so the driver samples it
          if (ph == `PHASE_LAST) begin
            fs      <= 1'b0;
            slot    <= 8'h00;
            nib_idx <= 5'h00;
            if (line == lines - 8'h01) begin
              line <= 8'h00;
              pol  <= ~pol;
            end else begin
              line <= line + 8'h01;
            end
            streaming <= ctrl[`CTRL_STREAM];
            state     <= ctrl[`CTRL_RUN] ? lcd_pkg::ST_SHIFT
                         : lcd_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Link outputs straight from flops
  assign link.data_shift_strobe = strobe;
  assign link.pixel_nibble      = nib;
  assign link.line_latch_pulse  = lp;
  assign link.frame_start_pulse = fs;
  assign link.ac_polarity       = pol;
  assign link.forced_blank_n    = ctrl[`CTRL_BLANK_N];

endmodule

// [verilog/lcd_link_if.sv]
// Pixel link between display controller and segment driver
`timescale 1ns/1ps
interface lcd_link_if;
  logic       data_shift_strobe;
  logic [3:0] pixel_nibble;
  logic       line_latch_pulse;
  logic       frame_start_pulse;
  logic       ac_polarity;
  logic       forced_blank_n;

  modport controller (
    output data_shift_strobe,
    output pixel_nibble,
    output line_latch_pulse,
    output frame_start_pulse,
    output ac_polarity,
    output forced_blank_n
  );

  modport driver (
    input data_shift_strobe,
    input pixel_nibble,
    input line_latch_pulse,
    input frame_start_pulse,
    input ac_polarity,
    input forced_blank_n
  );
endinterface

// [verilog/lcd_pkg.sv]
// Types shared by the segment driver and the display controller
package lcd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_LATCH = 4'b0100,
    ST_GAP   = 4'b1000
  } ctrl_state_t;

  typedef enum logic [1:0] {
    DRIVE_LEVEL_0 = 2'h0,
    DRIVE_LEVEL_2 = 2'h1,
    DRIVE_LEVEL_3 = 2'h2,
    DRIVE_LEVEL_5 = 2'h3
  } drive_level_t;
endpackage

// [verilog/lcd_segment_driver.sv]
// Segment driver with 200 x 80 display memory and self-refresh
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "lcd_defs.svh"
module lcd_segment_driver (
  input  wire logic     hclk,
  input  wire logic     hresetn,
  lcd_link_if.driver    link,
  input  wire logic     shift_direction_select,
  input  wire logic     chain_enable_io1_in,
  output logic          chain_enable_io1_out,
  output logic          chain_enable_io1_oe,
  input  wire logic     chain_enable_io2_in,
  output logic          chain_enable_io2_out,
  output logic          chain_enable_io2_oe,
  output logic [159:0]  seg_level,
  output logic          self_refresh
);

  logic [11:0]  raw;
  logic [11:0]  sync1;
  logic [11:0]  sync2;
  logic [3:0]   nib_s;
  logic         strobe_s;
  logic         lp_s;
  logic         fs_s;
  logic         pol_s;
  logic         blank_n_s;
  logic         io1_s;
  logic         io2_s;
  logic         shl_s;
  logic         enable;
  logic         strobe_g;
  logic [3:0]   nib_g;
  logic         strobe_g_d;
  logic         lp_d;
  logic         lp_fall;
  logic         capture;
  logic [4:0]   nib_cnt;
  logic         got_data;
  logic [79:0]  data_reg;
  logic [79:0]  next_data_reg;
  logic [6:0]   lo_up;
  logic [6:0]   lo_down;
  logic         chain_out;
  logic [7:0]   row;
  logic [7:0]   row_sel;
  logic [79:0]  out_latch;
  logic [79:0]  write_reg;
  logic         wr_pend;
  logic [7:0]   wr_row;
  logic [79:0]  mem [0:199];

  //////////////////////////////////////////////////////////////////////////
  // Every pin passes two flops; nothing reads the first stage
  assign raw = {shift_direction_select, chain_enable_io1_in,
                chain_enable_io2_in, link.ac_polarity,
                link.forced_blank_n, link.frame_start_pulse,
                link.line_latch_pulse, link.data_shift_strobe,
                link.pixel_nibble};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  assign shl_s     = sync2[11];
  assign io1_s     = sync2[10];
  assign io2_s     = sync2[9];
  assign pol_s     = sync2[8];
  assign blank_n_s = sync2[7];
  assign fs_s      = sync2[6];
  assign lp_s      = sync2[5];
  assign strobe_s  = sync2[4];
  assign nib_s     = sync2[3:0];

  //////////////////////////////////////////////////////////////////////////
  // Chain pins swap direction with the shift select
  assign enable = ~(shl_s ? io1_s : io2_s);
  assign chain_enable_io1_oe  = ~shl_s;
  assign chain_enable_io2_oe  = shl_s;
  assign chain_enable_io1_out = chain_out;
  assign chain_enable_io2_out = chain_out;

  // Power save: gated strobe and data sit low while disabled
  assign strobe_g = strobe_s & enable;
  assign nib_g    = enable ? nib_s : 4'h0;

  // Edge detection on the synchronised copies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_g_d <= 1'b0;
      lp_d       <= 1'b0;
    end else begin
      strobe_g_d <= strobe_g;
      lp_d       <= lp_s;
    end
  end

  assign lp_fall = lp_d & ~lp_s;
  // Enable falling mid-strobe would look like an edge, hence the guard
  assign capture = strobe_g_d & ~strobe_g & enable
                   & (nib_cnt != `LINE_NIBBLES);

  //////////////////////////////////////////////////////////////////////////
  // Nibble placement: D3 lands on the outermost column
  assign lo_up   = {nib_cnt, 2'b00};
  assign lo_down = 7'h4C - {nib_cnt, 2'b00};

  always_comb begin
    next_data_reg = data_reg;
    if (shl_s) begin
      next_data_reg[lo_up +: 4] = {nib_g[0], nib_g[1],
                                   nib_g[2], nib_g[3]};
    end else begin
      next_data_reg[lo_down +: 4] = nib_g;
    end
  end

  // Line capture; count and data flag restart at each latch fall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= 80'h0;
      nib_cnt  <= 5'h00;
      got_data <= 1'b0;
    end else if (lp_fall) begin
      nib_cnt  <= 5'h00;
      got_data <= 1'b0;
    end else if (capture) begin
      data_reg <= next_data_reg;
      nib_cnt  <= nib_cnt + 5'h01;
      got_data <= 1'b1;
    end
  end

  // Chain out: set by latch pulse, cleared on the twentieth nibble
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_out <= 1'b1;
    end else if (lp_s) begin
      chain_out <= 1'b1;
    end else if (capture && nib_cnt == `LINE_NIBBLES - 5'h01) begin
      chain_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Row select: frame start sampled at the latch fall
  assign row_sel = fs_s ? 8'h00 : row;

  // Latch fall: load outputs, stage the write, step the row.
  // Fresh line data bypasses memory so the display does not lag a frame.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row          <= 8'h00;
      out_latch    <= 80'h0;
      write_reg    <= 80'h0;
      wr_pend      <= 1'b0;
      wr_row       <= 8'h00;
      self_refresh <= 1'b0;
    end else if (lp_fall) begin
      out_latch    <= got_data ? data_reg : mem[row_sel];
      write_reg    <= data_reg;
      wr_pend      <= got_data;
      wr_row       <= row_sel;
      self_refresh <= ~got_data;
      row          <= (row_sel == `ROW_LAST) ? 8'h00
                      : row_sel + 8'h01;
    end else begin
      wr_pend <= 1'b0;
    end
  end

  // Display memory write; blanking never touches it
  always_ff @(posedge hclk) begin
    if (wr_pend) begin
      mem[wr_row] <= write_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-column drive level, registered; blank applies in every mode
  for (genvar i = 0; i < `LINE_BITS; i++) begin : g_col
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        seg_level[2*i +: 2] <= lcd_pkg::DRIVE_LEVEL_0;
      end else if (!blank_n_s) begin
        seg_level[2*i +: 2] <= lcd_pkg::DRIVE_LEVEL_0;
      end else begin
        unique case ({out_latch[i], pol_s})
          2'b11: seg_level[2*i +: 2] <= lcd_pkg::DRIVE_LEVEL_0;
          2'b10: seg_level[2*i +: 2] <= lcd_pkg::DRIVE_LEVEL_5;
          2'b01: seg_level[2*i +: 2] <= lcd_pkg::DRIVE_LEVEL_2;
          2'b00: seg_level[2*i +: 2] <= lcd_pkg::DRIVE_LEVEL_3;
        endcase
      end
    end
  end

endmodule
